// *** src/branch_bit_flag_exec.sv ***
`timescale 1ns/100ps
module branch_bit_flag_exec (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [7:0] io_out,
    output logic global_irq_en
);
    import bbf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    // Architectural state
    logic [15:0] pc_r; // Program counter
    logic [7:0] status_flags_reg; // C Z N V S H T I
    logic [7:0] data_r; // Working register operand/result
    logic [7:0] io_r; // I/O register driven onto pins
    logic [31:0] instr_r; // Last instruction word written
    logic taken_r; // Last instruction was a taken branch
    state_t state_r; // Sequencer state
    state_t state_nxt;

    // Bus state
    logic wr_pend_r; // Write data phase in progress
    logic rd_pend_r; // Read data phase in progress
    logic rd_done_r; // Read data already latched
    logic [7:0] addr_r; // Latched byte address
    logic [31:0] hrdata_r; // Read data flop

    // Decoded instruction
    op_t ex_op;
    logic [2:0] ex_idx;
    logic [7:0] ex_k;
    logic [15:0] k_ext;
    logic [1:0] br_dec;
    logic is_branch;
    logic br_taken;
    logic is_shift;
    logic two_cycle;

    // Shift datapath
    logic [7:0] sh_res;
    logic sh_cout;

    // Control
    logic busy;
    logic addr_accept;
    logic wr_fire;
    logic exec_now;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Branch decode: {is_branch, condition_true}
    function automatic logic [1:0] branch_eval(
        input op_t op,
        input logic [2:0] idx,
        input logic [7:0] f
    );
        logic [1:0] r;
        r = 2'b00;
        case (op)
            OP_BR_IDX_SET: r = {1'b1, f[idx]}; // RQ1
            OP_BR_IDX_CLR: r = {1'b1, ~f[idx]}; // RQ1
            OP_BR_EQ: r = {1'b1, f[F_Z]}; // RQ2
            OP_BR_NE: r = {1'b1, ~f[F_Z]}; // RQ2
            OP_BR_CS: r = {1'b1, f[F_C]}; // RQ3
            OP_BR_LO: r = {1'b1, f[F_C]}; // RQ3
            OP_BR_CC: r = {1'b1, ~f[F_C]}; // RQ3
            OP_BR_SH: r = {1'b1, ~f[F_C]}; // RQ3
            OP_BR_MI: r = {1'b1, f[F_N]}; // RQ4
            OP_BR_PL: r = {1'b1, ~f[F_N]}; // RQ4
            OP_BR_GE: r = {1'b1, ~(f[F_N] ^ f[F_V])}; // RQ5
            OP_BR_LT: r = {1'b1, f[F_N] ^ f[F_V]}; // RQ19
            OP_BR_HS: r = {1'b1, f[F_H]}; // RQ6
            OP_BR_HC: r = {1'b1, ~f[F_H]}; // RQ6
            OP_BR_TS: r = {1'b1, f[F_T]}; // RQ7
            OP_BR_TC: r = {1'b1, ~f[F_T]}; // RQ7
            OP_BR_VS: r = {1'b1, f[F_V]}; // RQ8
            OP_BR_VC: r = {1'b1, ~f[F_V]}; // RQ8
            OP_BR_IE: r = {1'b1, f[F_I]}; // RQ9
            OP_BR_ID: r = {1'b1, ~f[F_I]}; // RQ9
            default: r = 2'b00;
        endcase
        return r;
    endfunction

    // Register read mux; unmapped offsets read zero
    function automatic logic [31:0] reg_read(input logic [7:0] a);
        logic [31:0] v;
        v = WORD_ZERO;
        case (a)
            ADDR_INSTR: v = instr_r;
            ADDR_PC: v = {16'h0000, pc_r};
            ADDR_FLAGS: v = {24'h000000, status_flags_reg};
            ADDR_DATA: v = {24'h000000, data_r};
            ADDR_IO: v = {24'h000000, io_r};
            ADDR_STATUS: begin
                v[ST_BUSY_BIT] = busy;
                v[ST_TAKEN_BIT] = taken_r;
            end
            default: v = WORD_ZERO;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decode

    // Instruction fields and derived controls
    always_comb begin
        ex_op = op_t'(instr_r[OP_MSB:OP_LSB]);
        ex_idx = instr_r[IDX_MSB:IDX_LSB];
        ex_k = instr_r[K_MSB:K_LSB];
        // Offset is signed, so extend its sign into the pc width
        k_ext = {{8{ex_k[BYTE_MSB]}}, ex_k};
        br_dec = branch_eval(ex_op, ex_idx, status_flags_reg);
        is_branch = br_dec[1];
        br_taken = br_dec[1] & br_dec[0];
        is_shift = (ex_op == OP_SHL) || (ex_op == OP_ROL_C) ||
                   (ex_op == OP_ROR_C) || (ex_op == OP_SHR_A);
        two_cycle = br_taken || (ex_op == OP_IO_SET) ||
                    (ex_op == OP_IO_CLR); // RQ10 RQ18
    end

    // Shift and rotate datapath
    shift_unit shift_unit_i (
        .op(ex_op),
        .val(data_r),
        .cin(status_flags_reg[F_C]),
        .res(sh_res),
        .cout(sh_cout)
    );

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave

    assign busy = (state_r != ST_IDLE);
    assign addr_accept = hsel && htrans[1] && hready;
    // Writes wait out a running instruction rather than being dropped
    assign wr_fire = wr_pend_r && !busy;
    assign exec_now = (state_r == ST_EXEC);

    // One wait state on reads, stall on writes while busy
    assign hreadyout = !(rd_pend_r && !rd_done_r) && !(wr_pend_r && busy);
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= BYTE_RST;
        end else if (hready) begin
            wr_pend_r <= addr_accept && hwrite;
            rd_pend_r <= addr_accept && !hwrite;
            // Only the low byte decodes; higher bits alias
            addr_r <= haddr[ADDR_W-1:0];
        end
    end

    // Read data latched in the wait cycle, after any prior write landed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_done_r <= 1'b0;
            hrdata_r <= WORD_ZERO;
        end else begin
            rd_done_r <= rd_pend_r && !rd_done_r;
            if (rd_pend_r && !rd_done_r) begin
                hrdata_r <= reg_read(addr_r);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Next state: exec one cycle, hold one more for two-cycle ops
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (wr_fire && addr_r == ADDR_INSTR) begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_nxt = two_cycle ? ST_HOLD : ST_IDLE; // RQ18
            end
            ST_HOLD: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Instruction word and taken indicator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_r <= WORD_ZERO;
            taken_r <= 1'b0;
        end else if (wr_fire && addr_r == ADDR_INSTR) begin
            instr_r <= hwdata;
            taken_r <= 1'b0;
        end else if (exec_now) begin
            taken_r <= br_taken;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Architectural updates

    // Program counter: relative target when taken, else next word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_r <= PC_RST;
        end else if (exec_now) begin
            if (br_taken) begin
                pc_r <= pc_r + k_ext + PC_STEP; // RQ1
            end else begin
                pc_r <= pc_r + PC_STEP; // RQ18
            end
        end else if (wr_fire && addr_r == ADDR_PC) begin
            pc_r <= hwdata[PC_W-1:0];
        end
    end

    // Status flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_flags_reg <= FLAGS_RST;
        end else if (exec_now) begin
            if (is_shift) begin
                // S and H left alone; only Z C N V move
                status_flags_reg[F_Z] <= (sh_res == BYTE_RST); // RQ11
                status_flags_reg[F_C] <= sh_cout; // RQ11
                status_flags_reg[F_N] <= sh_res[BYTE_MSB]; // RQ11
                status_flags_reg[F_V] <= sh_res[BYTE_MSB] ^ sh_cout; // RQ11
            end else if (ex_op == OP_IDX_FLAG_ON) begin
                status_flags_reg[ex_idx] <= 1'b1; // RQ15
            end else if (ex_op == OP_IDX_FLAG_OFF) begin
                status_flags_reg[ex_idx] <= 1'b0; // RQ15
            end else if (ex_op[OP_MSB:OP_MSB-2] == DED_ON_TAG) begin
                status_flags_reg[ex_op[2:0]] <= 1'b1; // RQ15
            end else if (ex_op[OP_MSB:OP_MSB-2] == DED_OFF_TAG) begin
                status_flags_reg[ex_op[2:0]] <= 1'b0; // RQ15
            end else if (ex_op == OP_BIT_TO_XFER) begin
                status_flags_reg[F_T] <= data_r[ex_idx]; // RQ16
            end
        end else if (wr_fire && addr_r == ADDR_FLAGS) begin
            status_flags_reg <= hwdata[BYTE_MSB:BYTE_LSB];
        end
    end

    // Working register: shift results and transfer-flag bit load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_r <= BYTE_RST;
        end else if (exec_now) begin
            if (is_shift) begin
                data_r <= sh_res; // RQ12 RQ13 RQ14
            end else if (ex_op == OP_XFER_TO_BIT) begin
                data_r[ex_idx] <= status_flags_reg[F_T]; // RQ17
            end
        end else if (wr_fire && addr_r == ADDR_DATA) begin
            data_r <= hwdata[BYTE_MSB:BYTE_LSB];
        end
    end

    // I/O register: single-bit set and clear, flags untouched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_r <= BYTE_RST;
        end else if (exec_now) begin
            if (ex_op == OP_IO_SET) begin
                io_r[ex_idx] <= 1'b1; // RQ10
            end else if (ex_op == OP_IO_CLR) begin
                io_r[ex_idx] <= 1'b0; // RQ10
            end
        end else if (wr_fire && addr_r == ADDR_IO) begin
            io_r <= hwdata[BYTE_MSB:BYTE_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs

    // Straight from flops, no glitches at the pins
    assign io_out = io_r;
    assign global_irq_en = status_flags_reg[F_I];

endmodule

// *** src/bbf_pkg.sv ***
// Operation
// RQ1: Indexed flag branch: pc plus offset plus one
// RQ2: Equal/not-equal branches test the zero flag
// RQ3: Carry/lower and clear/same-or-higher test carry
// RQ4: Minus/plus branches test the negative flag
// RQ5: Signed greater-or-equal taken when N xor V clear
// RQ6: Half-carry branches test the half-carry flag
// RQ7: Transfer-flag branches test the transfer flag
// RQ8: Overflow branches test the overflow flag
// RQ9: Interrupt branches test global interrupt enable
// RQ10: I/O bit set/clear, flags untouched, two cycles
// RQ11: Logical left shift, zero in, updates ZCNV
// RQ12: Rotate left through carry, updates ZCNV
// RQ13: Rotate right through carry, updates ZCNV
// RQ14: Arithmetic right shift moves bits down
// RQ15: Dedicated and indexed flag set/clear, one cycle
// RQ16: Register bit copied into transfer flag
// RQ17: Transfer flag copied into register bit
// RQ18: Branch not taken one cycle, taken two
// RQ19: Signed less-than taken when N xor V set
// RQ20: Arithmetic right shift keeps sign, bit0 to carry
package bbf_pkg;

    // Byte geometry
    localparam int BYTE_MSB = 7;
    localparam int BYTE_LSB = 0;
    localparam int PC_W = 16;
    localparam int ADDR_W = 8;

    // Register byte addresses
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_PC = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0C;
    localparam logic [7:0] ADDR_IO = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // Instruction word fields
    localparam int OP_LSB = 0;
    localparam int OP_MSB = 5;
    localparam int IDX_LSB = 8;
    localparam int IDX_MSB = 10;
    localparam int K_LSB = 16;
    localparam int K_MSB = 23;

    // Status word bits
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_TAKEN_BIT = 1;

    // Flag positions inside status_flags_reg
    localparam int F_C = 0;
    localparam int F_Z = 1;
    localparam int F_N = 2;
    localparam int F_V = 3;
    localparam int F_S = 4;
    localparam int F_H = 5;
    localparam int F_T = 6;
    localparam int F_I = 7;

    // Reset values and pc step
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;
    localparam logic [15:0] PC_STEP = 16'h0001;

    // Dedicated flag op groups: upper three opcode bits
    localparam logic [2:0] DED_ON_TAG = 3'h4;
    localparam logic [2:0] DED_OFF_TAG = 3'h5;

    // Opcodes
    typedef enum logic [5:0] {
        OP_NOP = 6'h00,
        OP_BR_IDX_SET = 6'h01,
        OP_BR_IDX_CLR = 6'h02,
        OP_BR_EQ = 6'h03,
        OP_BR_NE = 6'h04,
        OP_BR_CS = 6'h05,
        OP_BR_CC = 6'h06,
        OP_BR_SH = 6'h07,
        OP_BR_LO = 6'h08,
        OP_BR_MI = 6'h09,
        OP_BR_PL = 6'h0A,
        OP_BR_GE = 6'h0B,
        OP_BR_LT = 6'h0C,
        OP_BR_HS = 6'h0D,
        OP_BR_HC = 6'h0E,
        OP_BR_TS = 6'h0F,
        OP_BR_TC = 6'h10,
        OP_BR_VS = 6'h11,
        OP_BR_VC = 6'h12,
        OP_BR_IE = 6'h13,
        OP_BR_ID = 6'h14,
        OP_IO_SET = 6'h15,
        OP_IO_CLR = 6'h16,
        OP_SHL = 6'h17,
        OP_ROL_C = 6'h18,
        OP_ROR_C = 6'h19,
        OP_SHR_A = 6'h1A,
        OP_IDX_FLAG_ON = 6'h1B,
        OP_IDX_FLAG_OFF = 6'h1C,
        OP_BIT_TO_XFER = 6'h1D,
        OP_XFER_TO_BIT = 6'h1E,
        OP_CARRY_ON = 6'h20,
        OP_ZERO_ON = 6'h21,
        OP_NEG_ON = 6'h22,
        OP_OVF_ON = 6'h23,
        OP_SIGN_ON = 6'h24,
        OP_HALF_ON = 6'h25,
        OP_XFER_ON = 6'h26,
        OP_GLOBAL_IRQ_ON = 6'h27,
        OP_CARRY_OFF = 6'h28,
        OP_ZERO_OFF = 6'h29,
        OP_NEG_OFF = 6'h2A,
        OP_OVF_OFF = 6'h2B,
        OP_SIGN_OFF = 6'h2C,
        OP_HALF_OFF = 6'h2D,
        OP_XFER_OFF = 6'h2E,
        OP_GLOBAL_IRQ_OFF = 6'h2F
    } op_t;

    // Execution sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_HOLD = 2'b10
    } state_t;

endpackage

// *** src/shift_unit.sv ***
`timescale 1ns/100ps
module shift_unit (
    input wire bbf_pkg::op_t op,
    input wire logic [7:0] val,
    input wire logic cin,
    output logic [7:0] res,
    output logic cout
);
    import bbf_pkg::*;

    // Shift and rotate datapath, pure combinational
    always_comb begin
        res = val;
        cout = cin;
        case (op)
            OP_SHL: begin
                res = {val[BYTE_MSB-1:BYTE_LSB], 1'b0}; // RQ11
                cout = val[BYTE_MSB]; // RQ11
            end
            OP_ROL_C: begin
                res = {val[BYTE_MSB-1:BYTE_LSB], cin}; // RQ12
                cout = val[BYTE_MSB]; // RQ12
            end
            OP_ROR_C: begin
                res = {cin, val[BYTE_MSB:BYTE_LSB+1]}; // RQ13
                cout = val[BYTE_LSB]; // RQ13
            end
            OP_SHR_A: begin
                // Sign bit replicated so negative values stay negative
                res = {val[BYTE_MSB], val[BYTE_MSB:BYTE_LSB+1]}; // RQ14 RQ20
                cout = val[BYTE_LSB]; // RQ20
            end
            default: begin
                res = val;
                cout = cin;
            end
        endcase
    end
endmodule

// *** bench/bbf_props.sv ***
`timescale 1ns/100ps
module bbf_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] io_out,
    input wire logic global_irq_en
);
    import bbf_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////
    // Data phase tracker
    logic pend_r;
    logic pend_wr_r;
    logic [7:0] pend_a_r;
    logic ioset_r; // I/O bit set launched
    logic irqon_r; // Global enable set launched
    logic [2:0] io_idx_r;
    wire logic acc = hsel && htrans[1] && hready;
    wire logic commit = pend_r && pend_wr_r && hready;
    // Address phase capture; a stalled phase keeps its address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_r <= 1'b0;
            pend_wr_r <= 1'b0;
            pend_a_r <= 8'h00;
        end else if (hready) begin
            pend_r <= acc;
            pend_wr_r <= hwrite;
            pend_a_r <= haddr[7:0];
        end
    end
    // Instruction launches of interest
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ioset_r <= 1'b0;
            irqon_r <= 1'b0;
            io_idx_r <= 3'h0;
        end else begin
            ioset_r <= commit && pend_a_r == ADDR_INSTR
                && hwdata[OP_MSB:OP_LSB] == OP_IO_SET;
            irqon_r <= commit && pend_a_r == ADDR_INSTR
                && hwdata[OP_MSB:OP_LSB] == OP_GLOBAL_IRQ_ON;
            // Index taken from every committed write, so later bus writes move it
            if (commit) begin
                io_idx_r <= hwdata[IDX_MSB:IDX_LSB];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    sequence rd_acc;
        acc && !hwrite;
    endsequence
    sequence rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not OKAY");
    a_read_wait: assert property (rd_acc |=> rd_answer)
        else $error("read wait state count wrong");
    a_stall_bound: assert property (!hreadyout |-> ##[1:3] hreadyout)
        else $error("stall too long");
    a_rst_values: assert property ($rose(hresetn) |-> io_out == 8'h00
        && !global_irq_en && hreadyout && hrdata == 32'h0)
        else $error("reset values wrong");
    a_io_write: assert property (commit && pend_a_r == ADDR_IO
        |=> io_out == $past(hwdata[7:0]))
        else $error("io write lost");
    a_irq_write: assert property (commit && pend_a_r == ADDR_FLAGS
        |=> global_irq_en == $past(hwdata[F_I]))
        else $error("flag write lost");
    a_rdata_hold: assert property (!(pend_r && !pend_wr_r)
        |=> $stable(hrdata))
        else $error("read data moved");
    a_io_bit_set: assert property (ioset_r |-> ##[0:2] io_out[io_idx_r])
        else $error("io bit not set");
    a_irq_op_on: assert property (irqon_r |-> ##[0:2] global_irq_en)
        else $error("global enable not set");
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    import bbf_pkg::*;
    typedef struct packed {
        logic [7:0] fl;
        logic [7:0] d;
        logic [5:0] op;
        logic [2:0] idx;
        logic [7:0] k;
        logic [15:0] pc;
        logic [7:0] efl;
        logic [7:0] ed;
    } row_t;
    logic hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, rv, pc_v, fl_v, d_v, st_v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, global_irq_en;
    logic [7:0] io_out;
    wire logic hready = hreadyout; // One slave drives the bus ready
    int fails, check_count, cyc;
    // Rows: start pc 0x10, flags, data, op, index, offset, outcomes
    row_t rows [30] = '{
        '{8'h08,0,OP_BR_IDX_SET,3,8'h05,16'h0016,8'h08,0},
        '{8'h08,0,OP_BR_IDX_CLR,3,8'h05,16'h0011,8'h08,0},
        '{8'h02,0,OP_BR_EQ,0,8'hFE,16'h000F,8'h02,0},
        '{8'h02,0,OP_BR_NE,0,8'hFE,16'h0011,8'h02,0},
        '{8'h01,0,OP_BR_CS,0,8'h7F,16'h0090,8'h01,0},
        '{8'h01,0,OP_BR_CC,0,8'h7F,16'h0011,8'h01,0},
        '{8'h00,0,OP_BR_SH,0,8'h01,16'h0012,8'h00,0},
        '{8'h00,0,OP_BR_LO,0,8'h01,16'h0011,8'h00,0},
        '{8'h04,0,OP_BR_MI,0,8'h80,16'hFF91,8'h04,0},
        '{8'h04,0,OP_BR_PL,0,8'h80,16'h0011,8'h04,0},
        '{8'h0C,0,OP_BR_GE,0,8'h02,16'h0013,8'h0C,0},
        '{8'h04,0,OP_BR_GE,0,8'h02,16'h0011,8'h04,0},
        '{8'h04,0,OP_BR_LT,0,8'h02,16'h0013,8'h04,0},
        '{8'h0C,0,OP_BR_LT,0,8'h02,16'h0011,8'h0C,0},
        '{8'h20,0,OP_BR_HS,0,8'h03,16'h0014,8'h20,0},
        '{8'h20,0,OP_BR_HC,0,8'h03,16'h0011,8'h20,0},
        '{8'h40,0,OP_BR_TS,0,8'h03,16'h0014,8'h40,0},
        '{8'h40,0,OP_BR_TC,0,8'h03,16'h0011,8'h40,0},
        '{8'h00,0,OP_BR_VS,0,8'h03,16'h0011,8'h00,0},
        '{8'h00,0,OP_BR_VC,0,8'h03,16'h0014,8'h00,0},
        '{8'h80,0,OP_BR_IE,0,8'h03,16'h0014,8'h80,0},
        '{8'h80,0,OP_BR_ID,0,8'h03,16'h0011,8'h80,0},
        '{8'h00,8'h81,OP_SHL,0,0,16'h0011,8'h09,8'h02},
        '{8'h01,8'h80,OP_ROL_C,0,0,16'h0011,8'h09,8'h01},
        '{8'h00,8'h01,OP_ROR_C,0,0,16'h0011,8'h0B,8'h00},
        '{8'h30,8'h81,OP_SHR_A,0,0,16'h0011,8'h35,8'hC0},
        '{8'h00,0,OP_IDX_FLAG_ON,6,0,16'h0011,8'h40,0},
        '{8'hFF,0,OP_IDX_FLAG_OFF,0,0,16'h0011,8'hFE,0},
        '{8'h00,8'h80,OP_BIT_TO_XFER,7,0,16'h0011,8'h40,8'h80},
        '{8'h40,8'h00,OP_XFER_TO_BIT,2,0,16'h0011,8'h40,8'h04}
    };
    branch_bit_flag_exec branch_bit_flag_exec_i (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .io_out(io_out), .global_irq_en(global_irq_en));
    ////////////////////////////////////////////////////////////////////
    // Clock and hang guard; 20000 cycles is far above the whole run
    always #50 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            summarize();
        end
    end
    task summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Ready and read data taken at the rising edge, before its updates land
    task wait_rdy(output logic [31:0] rd);
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // One single word transfer, entered just after a rising edge
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] rd);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy(rd);
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy(rd);
    endtask
    task run(input logic [7:0] fl, input logic [7:0] d, input logic [31:0] ins);
        xfer(ADDR_FLAGS, 1'b1, {24'h0, fl}, rv);
        xfer(ADDR_PC, 1'b1, 32'h10, rv);
        xfer(ADDR_DATA, 1'b1, {24'h0, d}, rv);
        xfer(ADDR_INSTR, 1'b1, ins, rv);
        xfer(ADDR_PC, 1'b0, 32'h0, pc_v);
        xfer(ADDR_FLAGS, 1'b0, 32'h0, fl_v);
        xfer(ADDR_DATA, 1'b0, 32'h0, d_v);
        xfer(ADDR_STATUS, 1'b0, 32'h0, st_v);
    endtask
    // Launch then read at once, while a long op is still running
    task io_case(input logic [7:0] init, input logic [5:0] op,
        input logic [7:0] exp);
        xfer(ADDR_IO, 1'b1, {24'h0, init}, rv);
        xfer(ADDR_FLAGS, 1'b1, 32'h5A, rv);
        xfer(ADDR_INSTR, 1'b1, {21'h0, 3'd5, 2'h0, op}, rv);
        xfer(ADDR_STATUS, 1'b0, 32'h0, rv);
        chk({31'h0, rv[ST_BUSY_BIT]}, 32'h1);
        xfer(ADDR_IO, 1'b0, 32'h0, rv);
        chk(rv, {24'h0, exp});
        chk({24'h0, io_out}, {24'h0, exp});
        xfer(ADDR_FLAGS, 1'b0, 32'h0, rv);
        chk(rv, 32'h5A);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 0;
        hresetn = 0;
        hsel = 1;
        haddr = 0;
        htrans = 0;
        hwrite = 0;
        hsize = 3'h2;
        hwdata = 0;
        fails = 0;
        check_count = 0;
        cyc = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        chk({23'h0, io_out, global_irq_en}, 32'h0);
        foreach (rows[i]) begin
            run(rows[i].fl, rows[i].d, {8'h00, rows[i].k, 5'h00,
                rows[i].idx, 2'h0, rows[i].op});
            chk(pc_v, {16'h0, rows[i].pc});
            chk(fl_v, {24'h0, rows[i].efl});
            chk(d_v, {24'h0, rows[i].ed});
            chk({31'h0, st_v[ST_TAKEN_BIT]}, {31'h0, rows[i].op <= 6'h14
                && rows[i].op != 6'h00 && rows[i].pc != 16'h0011});
        end
        $display("table done");
        for (int i = 0; i < 8; i++) begin
            run(8'h00, 8'h00, {26'h0, 6'h20 + 6'(i)});
            chk(fl_v, {24'h0, 8'h01 << i});
            chk({31'h0, global_irq_en}, {31'h0, i == 7});
            run(8'hFF, 8'h00, {26'h0, 6'h28 + 6'(i)});
            chk(fl_v, {24'h0, ~(8'h01 << i)});
        end
        $display("flag ops done");
        // Taken branch runs two cycles, untaken one
        run(8'h02, 8'h00, 32'h0);
        xfer(ADDR_INSTR, 1'b1, {8'h0, 8'h05, 10'h0, OP_BR_EQ}, rv);
        xfer(ADDR_STATUS, 1'b0, 32'h0, rv);
        chk({31'h0, rv[ST_BUSY_BIT]}, 32'h1);
        xfer(ADDR_FLAGS, 1'b1, 32'h0, rv);
        xfer(ADDR_INSTR, 1'b1, {8'h0, 8'h05, 10'h0, OP_BR_EQ}, rv);
        xfer(ADDR_STATUS, 1'b0, 32'h0, rv);
        chk({31'h0, rv[ST_BUSY_BIT]}, 32'h0);
        io_case(8'h00, OP_IO_SET, 8'h20);
        io_case(8'hFF, OP_IO_CLR, 8'hDF);
        xfer(8'h18, 1'b0, 32'h0, rv);
        chk(rv, 32'h0);
        $display("io and timing done");
        // Second reset in mid-run, global enable raised beforehand
        xfer(ADDR_FLAGS, 1'b1, 32'h80, rv);
        @(posedge hclk);
        chk({31'h0, global_irq_en}, 32'h1);
        hresetn <= 0;
        repeat (2) @(posedge hclk);
        chk({23'h0, io_out, global_irq_en}, 32'h0);
        hresetn <= 1;
        @(posedge hclk);
        xfer(ADDR_FLAGS, 1'b0, 32'h0, rv);
        chk(rv, 32'h0);
        $display("reset done");
        summarize();
    end
endmodule
bind branch_bit_flag_exec bbf_props bbf_props_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .io_out(io_out), .global_irq_en(global_irq_en));
